// File: logic/mbrs_slave.sv
/*
 * Slave end: collects request frames, checks them, executes register reads and writes, answers.
 * Assumes the master sends no new frame until the answer has ended and measured values are
 * presented combinationally on meas_value_i for the register number on meas_reg_o.
 */
`timescale 1ns/1ps
`include "mbrs_params.svh"
module mbrs_slave
	import mbrs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	mbrs_link_if.slave link,
	input wire logic [7:0] slave_addr_i,
	input wire logic [31:0] meas_value_i,
	output logic [15:0] meas_reg_o,
	output logic [31:0] baud_rate_o,
	output logic unlocked_o,
	output logic store_o,
	output logic frame_drop_o
);
	mbrs_byte_t rx_buf [0:255];
	mbrs_byte_t tx_buf_reg [0:6];
	mbrs_byte_t tx_buf_next [0:6];
	mbrs_dev_state_e state_reg, state_next;
	logic [8:0] rx_cnt_reg, rx_cnt_next;
	logic [8:0] rx_len_reg, rx_len_next;
	logic rx_ovf_reg, rx_ovf_next;
	mbrs_crc_t rx_crc_reg, rx_crc_next;
	logic [31:0] baud_reg, baud_next;
	logic [31:0] key_reg, key_next;
	logic unlock_reg, unlock_next;
	logic store_reg, store_next;
	logic drop_reg, drop_next;
	logic [3:0] tx_len_reg, tx_len_next;
	logic [3:0] tx_idx_reg, tx_idx_next;
	mbrs_crc_t tx_crc_reg, tx_crc_next;
	logic out_valid_reg, out_valid_next;
	logic out_last_reg, out_last_next;
	mbrs_byte_t out_data_reg, out_data_next;
	logic buf_we;
	mbrs_crc_t crc_in;
	mbrs_byte_t fc;
	logic [15:0] start_addr;
	logic [15:0] reg_count;
	logic [31:0] wr_value;
	logic [31:0] rd_value;
	logic is_hold;
	logic is_input;
	logic is_bcast;
	mbrs_byte_t exc;
	logic do_read;
	logic do_write;

	assign fc = rx_buf[1];
	assign start_addr = {rx_buf[2], rx_buf[3]};
	assign reg_count = {rx_buf[4], rx_buf[5]};
	assign wr_value = {rx_buf[7], rx_buf[8], rx_buf[9], rx_buf[10]};
	assign is_bcast = (rx_buf[0] == `MBRS_BCAST_ADDR);
	assign is_hold = (start_addr == `MBRS_REG_BAUD) || (start_addr == `MBRS_REG_KEY);
	assign is_input = !start_addr[0] && (((start_addr >= `MBRS_IN_LO_A) && (start_addr <= `MBRS_IN_HI_A))
		|| ((start_addr >= `MBRS_IN_LO_B) && (start_addr <= `MBRS_IN_HI_B)));
	assign meas_reg_o = start_addr + `MBRS_IN_REG_BASE;
	assign crc_in = mbrs_crc_step(rx_crc_reg, link.m2s_data);
	assign buf_we = (state_reg == MBRS_S_RX) && link.m2s_valid && (rx_cnt_reg < `MBRS_MAX_FRAME);

	// Validates the collected request; nothing is changed unless the whole check passes.
	always_comb begin
		exc = 8'h00;
		do_read = 1'b0;
		do_write = 1'b0;
		rd_value = (start_addr == `MBRS_REG_KEY) ? key_reg : baud_reg;
		unique case (fc)
			`MBRS_FC_RD_HOLD, `MBRS_FC_RD_INPUT: begin
				if ((fc == `MBRS_FC_RD_HOLD) ? is_input : is_hold) begin
					exc = `MBRS_EXC_FUNC;
				end else if (!((fc == `MBRS_FC_RD_HOLD) ? is_hold : is_input)) begin
					exc = `MBRS_EXC_ADDR;
				end else if ((reg_count != `MBRS_PAIR_COUNT) || (rx_len_reg != `MBRS_LEN_READ)) begin
					exc = `MBRS_EXC_VALUE;
				end else begin
					do_read = 1'b1;
				end
				if (fc == `MBRS_FC_RD_INPUT) begin
					rd_value = meas_value_i;
				end
			end
			`MBRS_FC_WR_SINGLE: begin
				exc = (is_hold || is_input) ? `MBRS_EXC_FUNC : `MBRS_EXC_ADDR;
			end
			`MBRS_FC_WR_MULTI: begin
				if (is_input) begin
					exc = `MBRS_EXC_FUNC;
				end else if (!is_hold) begin
					exc = `MBRS_EXC_ADDR;
				end else if ((reg_count != `MBRS_PAIR_COUNT) || (rx_buf[6] != `MBRS_PAIR_BYTES)
					|| (rx_len_reg != `MBRS_LEN_WRITE)) begin
					exc = `MBRS_EXC_VALUE;
				end else if (start_addr == `MBRS_REG_KEY) begin
					if ((wr_value == `MBRS_KEY_UNLOCK) || (wr_value == `MBRS_KEY_LOCK)) begin
						do_write = 1'b1;
					end else begin
						exc = `MBRS_EXC_VALUE;
					end
				end else if (!unlock_reg) begin
					exc = `MBRS_EXC_VALUE;
				end else begin
					do_write = 1'b1;
				end
			end
			default: begin
				exc = `MBRS_EXC_FUNC;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_len_next = rx_len_reg;
		rx_ovf_next = rx_ovf_reg;
		rx_crc_next = rx_crc_reg;
		baud_next = baud_reg;
		key_next = key_reg;
		unlock_next = unlock_reg;
		store_next = 1'b0;
		drop_next = 1'b0;
		tx_len_next = tx_len_reg;
		tx_idx_next = tx_idx_reg;
		tx_crc_next = tx_crc_reg;
		out_valid_next = 1'b0;
		out_last_next = 1'b0;
		out_data_next = out_data_reg;
		for (int i = 0; i < 7; i++) begin
			tx_buf_next[i] = tx_buf_reg[i];
		end
		unique case (state_reg)
			MBRS_S_RX: begin
				if (link.m2s_valid) begin
					rx_crc_next = crc_in;
					if (rx_cnt_reg < `MBRS_MAX_FRAME) begin
						rx_cnt_next = rx_cnt_reg + 9'h001;
					end else begin
						rx_ovf_next = 1'b1;
					end
					if (link.m2s_last) begin
						rx_cnt_next = 9'h000;
						rx_ovf_next = 1'b0;
						rx_crc_next = `MBRS_CRC_PRESET;
						rx_len_next = rx_cnt_reg + 9'h001;
						if (rx_ovf_reg || (rx_cnt_reg >= `MBRS_MAX_FRAME) || (rx_cnt_reg < 9'h003)
							|| (crc_in != 16'h0000)) begin
							drop_next = 1'b1;
						end else if ((rx_buf[0] == slave_addr_i) || (rx_buf[0] == `MBRS_BCAST_ADDR)) begin
							state_next = MBRS_S_EXEC;
						end
					end
				end
			end
			MBRS_S_EXEC: begin
				state_next = is_bcast ? MBRS_S_RX : MBRS_S_TX;
				if (do_write && (start_addr == `MBRS_REG_KEY)) begin
					key_next = wr_value;
					unlock_next = (wr_value == `MBRS_KEY_UNLOCK);
					store_next = (wr_value == `MBRS_KEY_LOCK);
				end else if (do_write) begin
					baud_next = wr_value;
				end
				if (is_bcast && (fc != `MBRS_FC_WR_MULTI)) begin
					baud_next = baud_reg;
					key_next = key_reg;
					unlock_next = unlock_reg;
					store_next = 1'b0;
				end
				tx_buf_next[0] = rx_buf[0];
				tx_buf_next[1] = fc;
				tx_idx_next = 4'h0;
				tx_crc_next = `MBRS_CRC_PRESET;
				if (exc != 8'h00) begin
					tx_buf_next[1] = fc | `MBRS_FC_EXC_FLAG;
					tx_buf_next[2] = exc;
					tx_len_next = 4'h3;
				end else if (do_read) begin
					tx_buf_next[2] = `MBRS_PAIR_BYTES;
					tx_buf_next[3] = rd_value[31:24];
					tx_buf_next[4] = rd_value[23:16];
					tx_buf_next[5] = rd_value[15:8];
					tx_buf_next[6] = rd_value[7:0];
					tx_len_next = 4'h7;
				end else begin
					for (int i = 2; i < 6; i++) begin
						tx_buf_next[i] = rx_buf[i];
					end
					tx_len_next = 4'h6;
				end
			end
			MBRS_S_TX: begin
				out_valid_next = 1'b1;
				tx_idx_next = tx_idx_reg + 4'h1;
				if (tx_idx_reg < tx_len_reg) begin
					out_data_next = tx_buf_reg[tx_idx_reg[2:0]];
					tx_crc_next = mbrs_crc_step(tx_crc_reg, tx_buf_reg[tx_idx_reg[2:0]]);
				end else if (tx_idx_reg == tx_len_reg) begin
					out_data_next = tx_crc_reg[7:0];
				end else begin
					out_data_next = tx_crc_reg[15:8];
					out_last_next = 1'b1;
					state_next = MBRS_S_RX;
				end
			end
			default: begin
				state_next = MBRS_S_RX;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (buf_we) begin
			rx_buf[rx_cnt_reg[7:0]] <= link.m2s_data;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= MBRS_S_RX;
			rx_cnt_reg <= 9'h000;
			rx_len_reg <= 9'h000;
			rx_ovf_reg <= 1'b0;
			rx_crc_reg <= `MBRS_CRC_PRESET;
			baud_reg <= `MBRS_BAUD_RESET;
			key_reg <= `MBRS_KEY_LOCK;
			unlock_reg <= 1'b0;
			store_reg <= 1'b0;
			drop_reg <= 1'b0;
			tx_len_reg <= 4'h0;
			tx_idx_reg <= 4'h0;
			tx_crc_reg <= `MBRS_CRC_PRESET;
			out_valid_reg <= 1'b0;
			out_last_reg <= 1'b0;
			out_data_reg <= 8'h00;
			for (int i = 0; i < 7; i++) begin
				tx_buf_reg[i] <= 8'h00;
			end
		end else begin
			state_reg <= state_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_len_reg <= rx_len_next;
			rx_ovf_reg <= rx_ovf_next;
			rx_crc_reg <= rx_crc_next;
			baud_reg <= baud_next;
			key_reg <= key_next;
			unlock_reg <= unlock_next;
			store_reg <= store_next;
			drop_reg <= drop_next;
			tx_len_reg <= tx_len_next;
			tx_idx_reg <= tx_idx_next;
			tx_crc_reg <= tx_crc_next;
			out_valid_reg <= out_valid_next;
			out_last_reg <= out_last_next;
			out_data_reg <= out_data_next;
			for (int i = 0; i < 7; i++) begin
				tx_buf_reg[i] <= tx_buf_next[i];
			end
		end
	end

	assign link.s2m_valid = out_valid_reg;
	assign link.s2m_data = out_data_reg;
	assign link.s2m_last = out_last_reg;
	assign baud_rate_o = baud_reg;
	assign unlocked_o = unlock_reg;
	assign store_o = store_reg;
	assign frame_drop_o = drop_reg;
endmodule

// File: common/mbrs_params.svh
/*
 * Constants shared by both ends of the serial register link: frame limits, function and exception
 * codes, register addresses, key values and the master's answer timeout.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef MBRS_PARAMS_SVH
`define MBRS_PARAMS_SVH
`define MBRS_MAX_FRAME 9'h100
`define MBRS_MIN_FRAME 9'h004
`define MBRS_CRC_PRESET 16'hFFFF
`define MBRS_CRC_POLY 16'hA001
`define MBRS_BCAST_ADDR 8'h00
`define MBRS_FC_RD_HOLD 8'h03
`define MBRS_FC_RD_INPUT 8'h04
`define MBRS_FC_WR_SINGLE 8'h06
`define MBRS_FC_WR_MULTI 8'h10
`define MBRS_FC_EXC_FLAG 8'h80
`define MBRS_EXC_FUNC 8'h01
`define MBRS_EXC_ADDR 8'h02
`define MBRS_EXC_VALUE 8'h03
`define MBRS_REG_BAUD 16'h9C45
`define MBRS_REG_KEY 16'h9C49
`define MBRS_KEY_UNLOCK 32'h00001267
`define MBRS_KEY_LOCK 32'h00000000
`define MBRS_BAUD_19200 32'h000000C0
`define MBRS_BAUD_RESET 32'h000000C0
`define MBRS_PAIR_COUNT 16'h0002
`define MBRS_PAIR_BYTES 8'h04
`define MBRS_IN_LO_A 16'h0002
`define MBRS_IN_HI_A 16'h1386
`define MBRS_IN_LO_B 16'h1388
`define MBRS_IN_HI_B 16'h13A2
`define MBRS_IN_REG_BASE 16'h7531
`define MBRS_LEN_READ 9'h008
`define MBRS_LEN_WRITE 9'h00D
`define MBRS_TIMEOUT 16'h4E20
`endif

// File: common/mbrs_pkg.sv
/*
 * Types and the checksum step shared by both ends.
 * Assumes the constants header is on the include path.
 */
`include "mbrs_params.svh"
package mbrs_pkg;
	typedef logic [7:0] mbrs_byte_t;
	typedef logic [15:0] mbrs_crc_t;
	typedef enum logic [1:0] {
		MBRS_S_RX = 2'b00,
		MBRS_S_EXEC = 2'b01,
		MBRS_S_TX = 2'b10
	} mbrs_dev_state_e;
	typedef enum logic [1:0] {
		MBRS_H_IDLE = 2'b00,
		MBRS_H_TX = 2'b01,
		MBRS_H_WAIT = 2'b10
	} mbrs_host_state_e;

	// Advances the reflected checksum by one byte.
	function automatic mbrs_crc_t mbrs_crc_step(input mbrs_crc_t crc, input mbrs_byte_t data);
		mbrs_crc_t c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			if (c[0]) begin
				c = (c >> 1) ^ `MBRS_CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction
endpackage

// File: common/mbrs_link_if.sv
/*
 * Byte stream between master and slave, one byte per valid cycle, last marking the frame end.
 * Assumes both ends run on the same clock; each byte is taken on the cycle it is valid.
 */
`timescale 1ns/1ps
interface mbrs_link_if;
	logic m2s_valid;
	logic [7:0] m2s_data;
	logic m2s_last;
	logic s2m_valid;
	logic [7:0] s2m_data;
	logic s2m_last;
	modport master (output m2s_valid, output m2s_data, output m2s_last,
		input s2m_valid, input s2m_data, input s2m_last);
	modport slave (input m2s_valid, input m2s_data, input m2s_last,
		output s2m_valid, output s2m_data, output s2m_last);
endinterface

// File: logic/mbrs_master.sv
/*
 * Master end: builds one request frame with checksum, sends it and decodes the answer.
 * Assumes the user holds a new request back while busy_o is high.
 */
`timescale 1ns/1ps
`include "mbrs_params.svh"
module mbrs_master
	import mbrs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_b_i,
	mbrs_link_if.master link,
	input wire logic req_valid_i,
	input wire logic [7:0] req_slave_i,
	input wire logic [7:0] req_fc_i,
	input wire logic [15:0] req_start_i,
	input wire logic [31:0] req_value_i,
	output logic busy_o,
	output logic rsp_valid_o,
	output logic rsp_exc_o,
	output logic [7:0] rsp_code_o,
	output logic [31:0] rsp_value_o,
	output logic rsp_bad_o
);
	mbrs_byte_t tx_buf_reg [0:10];
	mbrs_byte_t tx_buf_next [0:10];
	mbrs_host_state_e state_reg, state_next;
	logic [3:0] tx_len_reg, tx_len_next;
	logic [3:0] idx_reg, idx_next;
	mbrs_crc_t crc_reg, crc_next;
	logic [15:0] wait_reg, wait_next;
	logic out_valid_reg, out_valid_next;
	logic out_last_reg, out_last_next;
	mbrs_byte_t out_data_reg, out_data_next;
	logic rsp_valid_reg, rsp_valid_next;
	logic rsp_exc_reg, rsp_exc_next;
	logic rsp_bad_reg, rsp_bad_next;
	mbrs_byte_t code_reg, code_next;
	logic [31:0] value_reg, value_next;
	mbrs_crc_t crc_in;

	assign crc_in = mbrs_crc_step(crc_reg, link.s2m_data);

	always_comb begin
		state_next = state_reg;
		tx_len_next = tx_len_reg;
		idx_next = idx_reg;
		crc_next = crc_reg;
		wait_next = wait_reg;
		out_valid_next = 1'b0;
		out_last_next = 1'b0;
		out_data_next = out_data_reg;
		rsp_valid_next = 1'b0;
		rsp_exc_next = rsp_exc_reg;
		rsp_bad_next = rsp_bad_reg;
		code_next = code_reg;
		value_next = value_reg;
		for (int i = 0; i < 11; i++) begin
			tx_buf_next[i] = tx_buf_reg[i];
		end
		unique case (state_reg)
			MBRS_H_IDLE: begin
				if (req_valid_i) begin
					tx_buf_next[0] = req_slave_i;
					tx_buf_next[1] = req_fc_i;
					tx_buf_next[2] = req_start_i[15:8];
					tx_buf_next[3] = req_start_i[7:0];
					tx_buf_next[4] = 8'h00;
					tx_buf_next[5] = 8'(`MBRS_PAIR_COUNT);
					tx_buf_next[6] = `MBRS_PAIR_BYTES;
					tx_buf_next[7] = req_value_i[31:24];
					tx_buf_next[8] = req_value_i[23:16];
					tx_buf_next[9] = req_value_i[15:8];
					tx_buf_next[10] = req_value_i[7:0];
					tx_len_next = 4'h6;
					if (req_fc_i == `MBRS_FC_WR_MULTI) begin
						tx_len_next = 4'hB;
					end else if (req_fc_i == `MBRS_FC_WR_SINGLE) begin
						tx_buf_next[4] = req_value_i[15:8];
						tx_buf_next[5] = req_value_i[7:0];
					end
					idx_next = 4'h0;
					crc_next = `MBRS_CRC_PRESET;
					state_next = MBRS_H_TX;
				end
			end
			MBRS_H_TX: begin
				out_valid_next = 1'b1;
				idx_next = idx_reg + 4'h1;
				if (idx_reg < tx_len_reg) begin
					out_data_next = tx_buf_reg[idx_reg];
					crc_next = mbrs_crc_step(crc_reg, tx_buf_reg[idx_reg]);
				end else if (idx_reg == tx_len_reg) begin
					out_data_next = crc_reg[7:0];
				end else begin
					out_data_next = crc_reg[15:8];
					out_last_next = 1'b1;
					idx_next = 4'h0;
					crc_next = `MBRS_CRC_PRESET;
					wait_next = `MBRS_TIMEOUT;
					value_next = 32'h00000000;
					rsp_exc_next = 1'b0;
					rsp_bad_next = 1'b0;
					code_next = 8'h00;
					state_next = (tx_buf_reg[0] == `MBRS_BCAST_ADDR) ? MBRS_H_IDLE : MBRS_H_WAIT;
				end
			end
			MBRS_H_WAIT: begin
				wait_next = wait_reg - 16'h0001;
				if (link.s2m_valid) begin
					crc_next = crc_in;
					if (idx_reg != 4'hF) begin
						idx_next = idx_reg + 4'h1;
					end
					if ((idx_reg == 4'h1) && link.s2m_data[7]) begin
						rsp_exc_next = 1'b1;
					end
					if ((idx_reg == 4'h2) && rsp_exc_reg) begin
						code_next = link.s2m_data;
					end
					if ((idx_reg >= 4'h3) && (idx_reg <= 4'h6) && !rsp_exc_reg) begin
						value_next = {value_reg[23:0], link.s2m_data};
					end
					if (link.s2m_last) begin
						rsp_valid_next = 1'b1;
						rsp_bad_next = (crc_in != 16'h0000) || (idx_reg < 4'h3);
						state_next = MBRS_H_IDLE;
					end
				end else if (wait_reg == 16'h0000) begin
					rsp_valid_next = 1'b1;
					rsp_bad_next = 1'b1;
					state_next = MBRS_H_IDLE;
				end
			end
			default: begin
				state_next = MBRS_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= MBRS_H_IDLE;
			tx_len_reg <= 4'h0;
			idx_reg <= 4'h0;
			crc_reg <= `MBRS_CRC_PRESET;
			wait_reg <= 16'h0000;
			out_valid_reg <= 1'b0;
			out_last_reg <= 1'b0;
			out_data_reg <= 8'h00;
			rsp_valid_reg <= 1'b0;
			rsp_exc_reg <= 1'b0;
			rsp_bad_reg <= 1'b0;
			code_reg <= 8'h00;
			value_reg <= 32'h00000000;
			for (int i = 0; i < 11; i++) begin
				tx_buf_reg[i] <= 8'h00;
			end
		end else begin
			state_reg <= state_next;
			tx_len_reg <= tx_len_next;
			idx_reg <= idx_next;
			crc_reg <= crc_next;
			wait_reg <= wait_next;
			out_valid_reg <= out_valid_next;
			out_last_reg <= out_last_next;
			out_data_reg <= out_data_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_exc_reg <= rsp_exc_next;
			rsp_bad_reg <= rsp_bad_next;
			code_reg <= code_next;
			value_reg <= value_next;
			for (int i = 0; i < 11; i++) begin
				tx_buf_reg[i] <= tx_buf_next[i];
			end
		end
	end

	assign link.m2s_valid = out_valid_reg;
	assign link.m2s_data = out_data_reg;
	assign link.m2s_last = out_last_reg;
	assign busy_o = (state_reg != MBRS_H_IDLE);
	assign rsp_valid_o = rsp_valid_reg;
	assign rsp_exc_o = rsp_exc_reg;
	assign rsp_code_o = code_reg;
	assign rsp_value_o = value_reg;
	assign rsp_bad_o = rsp_bad_reg;
endmodule

// File: verification/mbrs_link_asserts.sv
/*
 * Concurrent checks on the byte link between the master and slave ends.
 * Assumes it is instantiated beside the link interface and sees its signals and the shared clock and reset.
 */
`timescale 1ns/1ps
module mbrs_link_asserts (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic m2s_valid,
	input wire logic [7:0] m2s_data,
	input wire logic m2s_last,
	input wire logic s2m_valid,
	input wire logic [7:0] s2m_data,
	input wire logic s2m_last
);
	logic [15:0] m_crc_reg, m_crc_next, m_crc_cur, s_crc_reg, s_crc_next, s_crc_cur;
	logic req_end;

	// Reflected checksum step, kept apart from the design's own copy.
	function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] d);
		logic [15:0] c;
		c = c_in ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	assign req_end = m2s_valid && m2s_last;

	always_comb begin
		m_crc_cur = crc_byte(m_crc_reg, m2s_data);
		s_crc_cur = crc_byte(s_crc_reg, s2m_data);
		m_crc_next = m_crc_reg;
		s_crc_next = s_crc_reg;
		if (m2s_valid) m_crc_next = m2s_last ? 16'hFFFF : m_crc_cur;
		if (s2m_valid) s_crc_next = s2m_last ? 16'hFFFF : s_crc_cur;
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			m_crc_reg <= 16'hFFFF;
			s_crc_reg <= 16'hFFFF;
		end else begin
			m_crc_reg <= m_crc_next;
			s_crc_reg <= s_crc_next;
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_rsp_start;
		$rose(s2m_valid);
	endsequence
	sequence s_exc_head;
		$rose(s2m_valid) ##1 s2m_data[7];
	endsequence

	a_req_last_valid: assert property (m2s_last |-> m2s_valid)
		else $error("request end marker without a byte");
	a_rsp_last_valid: assert property (s2m_last |-> s2m_valid)
		else $error("answer end marker without a byte");
	a_req_min_len: assert property ($rose(m2s_valid) |-> (m2s_valid && !m2s_last) [*3])
		else $error("request frame shorter than four bytes");
	a_rsp_contig: assert property (s2m_valid && !s2m_last |=> s2m_valid)
		else $error("gap inside an answer frame");
	a_rsp_latency: assert property (s_rsp_start |-> $past(req_end, 3))
		else $error("answer did not start three cycles after a request end");
	a_rsp_length: assert property (s_rsp_start |-> ##[4:8] s2m_last)
		else $error("answer length out of range");
	a_exc_length: assert property (s_exc_head |-> ##3 s2m_last)
		else $error("exception answer not five bytes");
	a_no_bcast_answer: assert property (s_rsp_start |-> s2m_data != 8'h00)
		else $error("answer sent from the broadcast address");
	a_no_overlap: assert property (s2m_valid |-> !m2s_valid)
		else $error("request byte sent during an answer");
	a_rsp_crc_ok: assert property (s2m_valid && s2m_last |-> s_crc_cur == 16'h0000)
		else $error("answer checksum wrong");
	a_req_crc_ok: assert property (req_end |-> m_crc_cur == 16'h0000)
		else $error("request checksum wrong");
endmodule

// File: verification/modbus_rtu_slave_interpreter_tb_top.sv
/*
 * Self-checking bench: master and slave ends joined by the link, driven from the master's user side.
 * Assumes the package, interface, design files and checker are compiled first.
 */
`timescale 1ns/1ps
`include "mbrs_params.svh"
module modbus_rtu_slave_interpreter_tb_top import mbrs_pkg::*;;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic [7:0] req_slave_i = 8'h00;
	logic [7:0] req_fc_i = 8'h00;
	logic [15:0] req_start_i = 16'h0000;
	logic [31:0] req_value_i = 32'h00000000;
	logic [31:0] meas_value_i, rsp_value_o, baud_rate_o;
	logic [15:0] meas_reg_o;
	logic [7:0] rsp_code_o;
	logic busy_o, rsp_valid_o, rsp_exc_o, rsp_bad_o, unlocked_o, store_o, frame_drop_o;
	int fail_count = 0;
	int check_count = 0;
	int rsp_seen = 0;
	int store_seen = 0;
	int drop_seen = 0;
	logic [7:0] m2s_q[$];

	always #25 mclk_i = ~mclk_i;
	assign meas_value_i = {meas_reg_o, ~meas_reg_o};

	mbrs_link_if lk();
	mbrs_master i_mbrs_master (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(lk.master), .req_valid_i(req_valid_i),
		.req_slave_i(req_slave_i), .req_fc_i(req_fc_i), .req_start_i(req_start_i), .req_value_i(req_value_i),
		.busy_o(busy_o), .rsp_valid_o(rsp_valid_o), .rsp_exc_o(rsp_exc_o), .rsp_code_o(rsp_code_o),
		.rsp_value_o(rsp_value_o), .rsp_bad_o(rsp_bad_o));
	mbrs_slave i_mbrs_slave (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(lk.slave), .slave_addr_i(8'h01),
		.meas_value_i(meas_value_i), .meas_reg_o(meas_reg_o), .baud_rate_o(baud_rate_o),
		.unlocked_o(unlocked_o), .store_o(store_o), .frame_drop_o(frame_drop_o));
	mbrs_link_asserts i_mbrs_link_asserts (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .m2s_valid(lk.m2s_valid),
		.m2s_data(lk.m2s_data), .m2s_last(lk.m2s_last), .s2m_valid(lk.s2m_valid), .s2m_data(lk.s2m_data),
		.s2m_last(lk.s2m_last));

	always @(posedge mclk_i) begin
		if (lk.m2s_valid === 1'b1) m2s_q.push_back(lk.m2s_data);
		if (rsp_valid_o === 1'b1) rsp_seen++;
		if (store_o === 1'b1) store_seen++;
		if (frame_drop_o === 1'b1) drop_seen++;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Issues one request and waits until the master is idle and the slave has settled.
	task automatic do_req(input logic [7:0] sl, input logic [7:0] fc, input logic [15:0] st, input logic [31:0] val);
		int n;
		n = 0;
		m2s_q.delete();
		rsp_seen = 0;
		store_seen = 0;
		req_slave_i = sl;
		req_fc_i = fc;
		req_start_i = st;
		req_value_i = val;
		req_valid_i = 1'b1;
		@(posedge mclk_i);
		#1;
		req_valid_i = 1'b0;
		while (busy_o !== 1'b0 && n < 25000) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk("request completes", 1, n < 25000);
		repeat (4) @(posedge mclk_i);
		#1;
	endtask

	task automatic exc_case(input logic [7:0] fc, input logic [15:0] st, input logic [31:0] val, input logic [7:0] code);
		do_req(8'h01, fc, st, val);
		chk("exception answered", 1, rsp_seen);
		chk("exception flag", 1, rsp_exc_o);
		chk("exception code", code, rsp_code_o);
		chk("exception checksum good", 0, rsp_bad_o);
	endtask

	task automatic t_read_param;
		do_req(8'h01, 8'h03, 16'h9C45, 32'h0);
		chk("read answered", 1, rsp_seen);
		chk("read exc", 0, rsp_exc_o);
		chk("baud reset value", 32'h000000C0, rsp_value_o);
		chk("read answer good", 0, rsp_bad_o);
		chk("read req length", 8, m2s_q.size());
		chk("read req count", 16'h0002, {m2s_q[4], m2s_q[5]});
		$display("read_param done");
	endtask

	task automatic t_locked_write;
		exc_case(8'h10, 16'h9C45, 32'h00000060, 8'h03);
		chk("baud kept", 32'h000000C0, baud_rate_o);
		$display("locked_write done");
	endtask

	task automatic t_unlock;
		do_req(8'h01, 8'h10, 16'h9C49, 32'h00001267);
		chk("unlock exc", 0, rsp_exc_o);
		chk("unlocked", 1, unlocked_o);
		chk("write req length", 13, m2s_q.size());
		chk("key bytes", 32'h00001267, {m2s_q[7], m2s_q[8], m2s_q[9], m2s_q[10]});
		chk("unlock req crc", 16'h83B9, {m2s_q[11], m2s_q[12]});
		$display("unlock done");
	endtask

	task automatic t_baud;
		do_req(8'h01, 8'h10, 16'h9C45, 32'h00000060);
		chk("baud written", 32'h00000060, baud_rate_o);
		do_req(8'h01, 8'h03, 16'h9C45, 32'h0);
		chk("baud read back", 32'h00000060, rsp_value_o);
		do_req(8'h01, 8'h10, 16'h9C45, 32'h000000C0);
		chk("baud 19200 code", 32'h000000C0, baud_rate_o);
		chk("baud req crc", 16'hCEF6, {m2s_q[11], m2s_q[12]});
		$display("baud done");
	endtask

	task automatic t_exceptions;
		logic [7:0] fcs[6] = '{8'h06, 8'h05, 8'h04, 8'h03, 8'h03, 8'h04};
		logic [15:0] sts[6] = '{16'h9C45, 16'h9C45, 16'h9C45, 16'h0002, 16'h2000, 16'h0003};
		logic [7:0] codes[6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02};
		for (int i = 0; i < 6; i++) begin
			exc_case(fcs[i], sts[i], 32'h0, codes[i]);
		end
		exc_case(8'h10, 16'h9C49, 32'h00001234, 8'h03);
		chk("bad key keeps level", 1, unlocked_o);
		$display("exceptions done");
	endtask

	task automatic t_input;
		do_req(8'h01, 8'h04, 16'h0002, 32'h0);
		chk("input value low block", {16'h7533, 16'h8ACC}, rsp_value_o);
		do_req(8'h01, 8'h04, 16'h1388, 32'h0);
		chk("input value high block", {16'h88B9, 16'h7746}, rsp_value_o);
		$display("input done");
	endtask

	task automatic t_lock;
		do_req(8'h01, 8'h10, 16'h9C49, 32'h0);
		chk("store pulse", 1, store_seen);
		chk("locked", 0, unlocked_o);
		chk("lock req crc", 16'hCEF3, {m2s_q[11], m2s_q[12]});
		$display("lock done");
	endtask

	task automatic t_bcast;
		do_req(8'h00, 8'h10, 16'h9C49, 32'h00001267);
		chk("broadcast unanswered", 0, rsp_seen);
		chk("broadcast unlock", 1, unlocked_o);
		do_req(8'h00, 8'h10, 16'h9C49, 32'h0);
		chk("broadcast lock", 0, unlocked_o);
		chk("broadcast store", 1, store_seen);
		$display("bcast done");
	endtask

	// A request to another address is ignored, so the master must give up on its own.
	task automatic t_timeout;
		do_req(8'h02, 8'h03, 16'h9C45, 32'h0);
		chk("timeout answered", 1, rsp_seen);
		chk("timeout marked bad", 1, rsp_bad_o);
		$display("timeout done");
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge mclk_i);
		#1;
		rst_b_i = 1'b1;
		t_read_param();
		t_locked_write();
		t_unlock();
		t_baud();
		t_exceptions();
		t_input();
		t_lock();
		t_bcast();
		t_timeout();
		chk("no dropped frames", 0, drop_seen);
		final_report();
	end

	initial begin
		#(90000 * 50);
		fail_count++;
		final_report();
	end
endmodule
